// *** qls_pkg.sv ***
// Package of constants for the quad lane static memory host controller
//
// Contract
// - Host forms wide access with lane mask
// - Host spaces addresses by read cycle time
// - Select read: enable low, address stable
// - Strobe write ends on strobe rising
// - Select write ends on first release
// - Host waits float delay before driving
package qls_pkg;
    // Geometry
    localparam int LANES     = 4;
    localparam int ADDR_W    = 19;
    localparam int LANE_W    = 8;
    localparam int DATA_W    = LANES * LANE_W;
    // Clock period in picoseconds (40 MHz)
    localparam int CLK_PS    = 25000;
    // Timing figures in picoseconds; plain defaults, no figures given
    localparam int ACCESS_PS = 20000;
    localparam int CYCLE_PS  = 20000;
    localparam int PULSE_PS  = 20000;
    localparam int FLOAT_PS  = 10000;
    // Least times round up to whole cycles, at least one; access adds one more cycle
    localparam int ACCESS_CYC = (ACCESS_PS + CLK_PS - 1) / CLK_PS + 1;
    localparam int CYCLE_CYC  = (CYCLE_PS + CLK_PS - 1) / CLK_PS;
    localparam int PULSE_CYC  = (PULSE_PS + CLK_PS - 1) / CLK_PS;
    localparam int FLOAT_CYC  = (FLOAT_PS + CLK_PS - 1) / CLK_PS;
    localparam int CNT_W      = 4;
    // Controller phases
    typedef enum logic [2:0] {
        QLS_IDLE, QLS_RD_WAIT, QLS_RD_DONE, QLS_WR_FLOAT,
        QLS_WR_PULSE, QLS_WR_END
    } qls_state_t;
endpackage

// *** qls_host.sv ***
// Host controller that drives the quad lane asynchronous static memory
`timescale 1ns/1ps
module qls_host import qls_pkg::*; (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                srst,
    // User request side
    input  wire logic                req_valid,
    input  wire logic                req_write,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [LANES-1:0]    req_lanes,
    input  wire logic [DATA_W-1:0]   req_wdata,
    output logic                     req_ready,
    output logic                     rsp_valid,
    output logic [DATA_W-1:0]        rsp_rdata,
    // Memory pins
    output logic [ADDR_W-1:0]        mem_addr,
    output logic [LANES-1:0]         lane_select_n,
    output logic [LANES-1:0]         lane_write_n,
    output logic                     drive_enable_n,
    input  wire logic [DATA_W-1:0]   dq_in,
    output logic [DATA_W-1:0]        dq_out,
    output logic [LANES-1:0]         dq_oe
);
    // Refuse timing counts that the phase timer cannot reach
    if (ACCESS_CYC >= (1 << CNT_W) || CYCLE_CYC >= (1 << CNT_W) ||
        PULSE_CYC >= (1 << CNT_W) || FLOAT_CYC >= (1 << CNT_W)) begin
        $error("Timing counts too large for phase timer");
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    qls_state_t              state_r, state_nxt;   // Phase
    logic [CNT_W-1:0]        cnt_r, cnt_nxt;       // Phase timer
    logic [LANES-1:0]        lanes_r;              // Captured lane mask
    logic                    rd_ok;                // Read delay met
    logic                    pulse_ok;             // Write pulse met
    logic                    float_ok;             // Float delay met

    assign rd_ok    = (cnt_r >= CNT_W'(ACCESS_CYC))
                      && (cnt_r >= CNT_W'(CYCLE_CYC));
    assign pulse_ok = cnt_r >= CNT_W'(PULSE_CYC);
    assign float_ok = cnt_r >= CNT_W'(FLOAT_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + CNT_W'(1);
        unique case (state_r)
            QLS_IDLE: begin
                cnt_nxt = '0;
                if (req_valid) begin
                    state_nxt = req_write ? QLS_WR_FLOAT : QLS_RD_WAIT;
                end
            end
            // hold select and enable past access delay
            QLS_RD_WAIT: begin
                if (rd_ok) begin
                    state_nxt = QLS_RD_DONE;
                end
            end
            QLS_RD_DONE: begin
                state_nxt = QLS_IDLE;
            end
            // wait float delay before driving data
            QLS_WR_FLOAT: begin
                if (float_ok) begin
                    state_nxt = QLS_WR_PULSE;
                    cnt_nxt   = '0;
                end
            end
            // strobe released after least pulse width
            QLS_WR_PULSE: begin
                if (pulse_ok) begin
                    state_nxt = QLS_WR_END;
                end
            end
            QLS_WR_END: begin
                state_nxt = QLS_IDLE;
            end
            default: state_nxt = QLS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin and response registers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r        <= QLS_IDLE;
            cnt_r          <= '0;
            lanes_r        <= '0;
            req_ready      <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_rdata      <= '0;
            mem_addr       <= '0;
            lane_select_n  <= '1;
            lane_write_n   <= '1;
            drive_enable_n <= 1'b1;
            dq_out         <= '0;
            dq_oe          <= '0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            rsp_valid <= 1'b0;
            req_ready <= (state_nxt == QLS_IDLE) && !req_valid;
            unique case (state_r)
                QLS_IDLE: begin
                    if (req_valid) begin
                        lanes_r       <= req_lanes;
                        mem_addr      <= req_addr;
                        lane_select_n <= ~req_lanes;
                        dq_out        <= req_wdata;
                        // enable low on reads, high on writes, strobe high, address held
                        drive_enable_n <= req_write;
                        req_ready      <= 1'b0;
                    end
                end
                QLS_RD_WAIT: begin
                    if (rd_ok) begin
                        rsp_rdata     <= dq_in;
                        rsp_valid     <= 1'b1;
                        lane_select_n <= '1;
                        drive_enable_n <= 1'b1;
                    end
                end
                QLS_WR_FLOAT: begin
                    if (float_ok) begin
                        lane_write_n <= ~lanes_r;
                        dq_oe        <= lanes_r;
                    end
                end
                QLS_WR_PULSE: begin
                    if (pulse_ok) begin
                        lane_write_n  <= '1;
                        lane_select_n <= '1;
                    end
                end
                QLS_WR_END: begin
                    dq_oe     <= '0;
                    rsp_valid <= 1'b1;
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address spacing monitor
    logic                    addr_load;            // Address taken this edge
    logic [CNT_W-1:0]        gap_r, gap_nxt;       // Cycles since last load

    // A new address is loaded when an idle phase takes a request
    assign addr_load = (state_r == QLS_IDLE) && req_valid;
    assign gap_nxt   = addr_load     ? '0 :
                       (gap_r == '1) ? gap_r :
                                       gap_r + CNT_W'(1);

    // Saturating gap counter, parked at its ceiling after reset
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            gap_r <= '1;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Read phase: select and drive enable low on captured lanes
    sequence s_read_open;
        state_r == QLS_RD_WAIT;
    endsequence
    sequence s_read_pins;
        drive_enable_n == 1'b0 && lane_select_n == ~lanes_r;
    endsequence
    // Write phase: strobe low until the least pulse is met
    sequence s_pulse_open;
        state_r == QLS_WR_PULSE && !pulse_ok;
    endsequence
    sequence s_strobe_held;
        lane_write_n == ~lanes_r && lane_select_n == ~lanes_r
        && dq_oe == lanes_r;
    endsequence
    // Write end: strobe and select rise while data still driven
    sequence s_pulse_close;
        state_r == QLS_WR_PULSE && pulse_ok;
    endsequence
    sequence s_pins_released;
        lane_write_n == '1 && lane_select_n == '1 && dq_oe == lanes_r;
    endsequence

    // address stable while a read is open
    a_addr_stable: assert property (
        @(posedge clk_sys) disable iff (srst)
        state_r == QLS_RD_WAIT && $past(state_r) == QLS_RD_WAIT
        |-> $stable(mem_addr))
        else $error("Address moved during read");
    // address loads spaced by read cycle
    a_addr_spacing: assert property (
        @(posedge clk_sys) disable iff (srst)
        addr_load |-> gap_r >= CNT_W'(CYCLE_CYC))
        else $error("Address changed before read cycle time");
    // data not driven while waiting the float delay
    a_float_wait: assert property (
        @(posedge clk_sys) disable iff (srst)
        state_r == QLS_WR_FLOAT |-> dq_oe == '0)
        else $error("Data driven before float delay");
    a_read_strobe: assert property (
        @(posedge clk_sys) disable iff (srst)
        state_r == QLS_RD_WAIT |-> lane_write_n == '1)
        else $error("Strobe low during read");
    a_read_pins: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_read_open |-> s_read_pins)
        else $error("Select or drive enable wrong during read");
    a_strobe_held: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_pulse_open |-> s_strobe_held)
        else $error("Write strobe released before least pulse");
    a_write_close: assert property (
        @(posedge clk_sys) disable iff (srst)
        s_pulse_close |=> s_pins_released)
        else $error("Write not ended cleanly");
endmodule

// *** qls_mem_model.sv ***
// Model of the four lane asynchronous static memory
`timescale 1ns/1ps
module qls_mem_model import qls_pkg::*; (
    // Memory pins
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [LANES-1:0]  lane_select_n,
    input  wire logic [LANES-1:0]  lane_write_n,
    input  wire logic              drive_enable_n,
    // Data lanes
    input  wire logic [DATA_W-1:0] dq_bus,
    output logic [DATA_W-1:0]      dq_dev = '0,
    output logic [LANES-1:0]       dev_oe
);
    // Sparse store keyed by lane and word
    logic [LANE_W-1:0] mem_r [bit [ADDR_W+1:0]];
    logic [LANES-1:0]  wr_r = '0;
    ////////////////////////////////////////////////////////////////
    // each lane stores its byte when its write ends
    always @(lane_select_n or lane_write_n) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_r[i] && !(~lane_select_n[i] & ~lane_write_n[i])) begin
                mem_r[{2'(i), mem_addr}] = dq_bus[i*LANE_W +: LANE_W];
            end
        end
        wr_r = ~lane_select_n & ~lane_write_n;
    end
    // lane drives only when selected, reading, enabled
    assign dev_oe = ~lane_select_n & lane_write_n
                    & {LANES{~drive_enable_n}};
    logic [DATA_W-1:0] rd_word;  // Stored bytes at the current address
    always @(mem_addr or dev_oe) begin
        for (int i = 0; i < LANES; i++) begin
            rd_word[i*LANE_W +: LANE_W] = mem_r.exists({2'(i), mem_addr}) ?
                mem_r[{2'(i), mem_addr}] : 8'ha5;
        end
        dq_dev = ~dq_dev;
        dq_dev <= #(ACCESS_PS / 1000.0) rd_word;
    end
endmodule

// *** quad_lane_async_sram_tb_top.sv ***
// Testbench for the quad lane static memory host controller
`timescale 1ns/1ps
module quad_lane_async_sram_tb_top import qls_pkg::*; ;
    // Stimulus
    logic              clk_sys = 0, srst = 1, req_valid = 0, req_write = 0;
    logic [ADDR_W-1:0] req_addr = '0, mem_addr;
    logic [LANES-1:0]  req_lanes = '0, lane_select_n, lane_write_n;
    logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, dq_out, dq_dev, dq_in;
    // Observed and bus state
    logic [LANES-1:0]  dq_oe, dev_oe;
    logic              req_ready, rsp_valid, drive_enable_n;
    logic [DATA_W-1:0] flt_r = 32'h5a5a5a5a;
    int                n_errors = 0, samples_checked = 0, cyc = 0;
    // Rows: write flag, address, lane mask, data
    logic [55:0] rows [9] = '{{1'b1, 19'h0, 4'hf, 32'h11223344},
        {1'b1, 19'h7ffff, 4'hf, 32'haabbccdd}, {1'b1, 19'h0, 4'h1, 32'h55},
        {1'b1, 19'h0, 4'h6, 32'h778800}, {1'b1, 19'h7ffff, 4'h8, 32'hee << 24},
        {1'b0, 19'h0, 4'hf, 32'h11778855},
        {1'b0, 19'h7ffff, 4'hf, 32'heebbccdd},
        {1'b0, 19'h7ffff, 4'h3, 32'hccdd}, {1'b0, 19'h0, 4'hc, 32'h11770000}};
    qls_host qls_host_i (
        .clk_sys(clk_sys), .srst(srst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_lanes(req_lanes),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .mem_addr(mem_addr),
        .lane_select_n(lane_select_n), .lane_write_n(lane_write_n),
        .drive_enable_n(drive_enable_n), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe(dq_oe));
    qls_mem_model qls_mem_model_i (.mem_addr, .lane_select_n, .lane_write_n,
        .drive_enable_n, .dq_bus(dq_in), .dq_dev, .dev_oe);
    ////////////////////////////////////////////////////////////////
    // Clock, floating pattern and hang guard
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        flt_r <= ~flt_r;
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            end_of_test();
        end
    end
    // Resolve each lane from whoever drives it
    always_comb for (int i = 0; i < LANES; i++)
        dq_in[i*8 +: 8] = dq_oe[i] ? dq_out[i*8 +: 8] :
                          dev_oe[i] ? dq_dev[i*8 +: 8] : flt_r[i*8 +: 8];
    // host and device never drive together
    always @(negedge clk_sys) if (!srst) chk(32'(dq_oe & dev_oe), 0);
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Hold reset eight cycles and check pins are parked
    task automatic park();
        srst = 1;
        repeat (8) @(negedge clk_sys);
        // selects, strobes, enable high, lanes released
        chk(32'({drive_enable_n, lane_select_n, lane_write_n, dq_oe,
                 req_ready}), 32'h3fe0);
        srst = 0;
    endtask
    task automatic xfer(input logic [55:0] q);
        while (req_ready !== 1'b1) @(negedge clk_sys);
        {req_write, req_addr, req_lanes, req_wdata} = q;
        req_valid = 1;
        @(negedge clk_sys);
        req_valid = 0;
        @(negedge clk_sys);
        chk(32'(mem_addr), 32'(q[54:36]));
        chk(32'(lane_select_n ^ q[35:32]), 32'hf);
        while (rsp_valid !== 1'b1) begin
            if (lane_write_n !== 4'hf)
                chk(32'(lane_write_n ^ q[35:32]), 32'hf);
            chk(32'(drive_enable_n), 32'(q[55]));
            @(negedge clk_sys);
        end
        for (int j = 0; j < LANES; j++) if (!q[55] && q[32+j])
            chk(32'(rsp_rdata[j*8 +: 8]), 32'(q[j*8 +: 8]));
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        park();
        for (int r = 0; r < 9; r++) xfer(rows[r]);
        // a write requested while busy is ignored
        while (req_ready !== 1'b1) @(negedge clk_sys);
        {req_valid, req_write} = 2'b10;
        {req_addr, req_lanes} = {19'h0, 4'hf};
        @(negedge clk_sys);
        {req_write, req_wdata} = {1'b1, 32'h0};
        @(negedge clk_sys);
        req_valid = 0;
        xfer(rows[5]);
        // contents survive a reset of the controller
        park();
        xfer(rows[6]);
        end_of_test();
    end
endmodule
